// File: rtl/reset_source_pkg.sv
// Constants for the reset source controller
package reset_source_pkg;
	// ==========================================================
	// Register bus
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 32;
	localparam logic [7:0]  OFF_BOR_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_CAUSE      = 8'h04;
	localparam logic [7:0]  OFF_PRST0      = 8'h08;
	localparam logic [7:0]  OFF_WDT_LOAD   = 8'h14;
	localparam logic [7:0]  OFF_WDT_CTRL   = 8'h18;
	localparam logic [7:0]  OFF_WDT_VALUE  = 8'h1C;
	localparam logic [7:0]  OFF_WDT_ICR    = 8'h20;
	localparam logic [7:0]  OFF_CORE_RST   = 8'h24;
	localparam logic [7:0]  OFF_OSC_CTRL   = 8'h28;
	// ==========================================================
	// Field positions
	localparam int          BOR_IRQ_EN_BIT = 0;
	localparam int          BOR_RST_EN_BIT = 1;
	localparam int          WDT_EN_BIT     = 0;
	localparam int          WDT_RST_EN_BIT = 1;
	localparam int          SYSREQ_BIT     = 2;
	localparam int          OSC_CHK_BIT    = 0;
	localparam int          CAUSE_EXT      = 0;
	localparam int          CAUSE_POR      = 1;
	localparam int          CAUSE_BOR      = 2;
	localparam int          CAUSE_SW       = 3;
	localparam int          CAUSE_WDT      = 4;
	localparam int          CAUSE_OSC      = 5;
	localparam int          CAUSE_W        = 6;
	// ==========================================================
	// Reset values
	localparam logic [5:0]  CAUSE_POR_VAL  = 6'h02;
	localparam logic [31:0] WDT_LOAD_RST   = 32'hFFFFFFFF;
	localparam logic [2:0]  SYNC_IDLE      = 3'h1;
	// ==========================================================
	// Timing
	localparam int          CLK_PERIOD_NS  = 25;
	localparam int          RELEASE_NS     = 250;
	localparam int          RELEASE_CYC    = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          NUM_PREGS      = 3;
	localparam int          PREG_BITS      = 32;
	typedef enum logic [1:0] {ST_ASSERT, ST_WAIT, ST_RUN} seq_state_type;
endpackage

// File: rtl/reset_source_controller.sv
// Reset source collection, cause record, release sequencing and watchdog
//
// Behaviour
// R1: Power-on reset resets core, peripherals and debug TAP together.
// R2: External pin resets core and peripherals; TAP only gets pin configuration reset.
// R3: Brown-out, software, watchdog, oscillator resets hit core and peripherals, never TAP.
// R4: Three registers, one bit per peripheral; setting then clearing resets that unit.
// R5: Peripheral software reset drives every reset line of the selected unit.
// R6: Peripheral reset bits follow the clock gating bit assignment.
// R7: Cause record flags each source and stays sticky until software clears it.
// R8: Power-on reset clears all cause flags except the power-on flag.
// R9: Hold reset until power-on detector releases, then start vector fetch.
// R10: Power-on detector resets only at first supply ramp.
// R11: Board holds the reset pin low at least its minimum pulse width.
// R12: Brown-out reset disabled after reset; software may enable it. Only power-on reset clears bor_ctrl; other resets keep its value.
// R13: Brown-out raises an interrupt or a system reset, by configuration.
// R14: Brown-out resets only while its reset enable bit is set.
// R15: Brown-out reset acts like the pin and holds until supply recovers.
// R16: System reset request bit asserts reset, then release and vector fetch.
// R17: Watchdog interrupts on first time-out, resets on second.
// R18: After first time-out the 32-bit counter reloads and counts on.
// R19: Watchdog resets only on zero with interrupt uncleared and reset enabled.
// R20: Software selects the shared pin's interrupt function; GPIO after reset. This controller has no pin function select.
// R21: Checked oscillator failure resets, flags the cause, and requests NMI.
// R22: Reset pin is synchronised before driving internal reset.
// R23: Cause record has one flag per reset source.
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller
	import reset_source_pkg::*;
#(
	parameter int NUM_REGS = reset_source_pkg::NUM_PREGS,
	parameter int REG_BITS = reset_source_pkg::PREG_BITS
) (
	input  wire logic                                 ref_clk_i,
	input  wire logic                                 rst_n_i,
	input  wire logic                                 ext_reset_n_i,
	input  wire logic                                 brownout_detect_i,
	input  wire logic                                 osc_fail_i,
	input  wire logic [reset_source_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [reset_source_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic                                 wr_i,
	input  wire logic                                 rd_i,
	output logic      [reset_source_pkg::DATA_W-1:0]  rdata_o,
	output logic                                      core_reset_n_o,
	output logic                                      periph_reset_n_o,
	output logic                                      tap_reset_n_o,
	output logic                                      tap_pin_cfg_reset_n_o,
	output logic      [NUM_REGS*REG_BITS-1:0]         unit_reset_n_o,
	output logic                                      boot_fetch_o,
	output logic                                      nmi_request_o,
	output logic                                      brownout_irq_o,
	output logic                                      watchdog_irq_o
);
	import reset_source_pkg::*;

	if (NUM_REGS != 3 || REG_BITS != 32) begin : g_bad_params
		$error("reset_source_controller: address map serves three 32-bit registers only");
	end

	// ==========================================================
	// Pin synchronisers: {osc, brown-out, reset pin}
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] pin_level;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
			sync3 <= SYNC_IDLE;
		end else begin
			sync1 <= {osc_fail_i, brownout_detect_i, ext_reset_n_i};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_level <= SYNC_IDLE;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (sync2[i] == sync3[i]) begin
					pin_level[i] <= sync3[i]; // R22
				end
			end
		end
	end

	logic ext_active;
	logic bor_level;
	logic osc_level;
	logic osc_prev;
	assign ext_active = !pin_level[0];
	assign bor_level  = pin_level[1];
	assign osc_level  = pin_level[2];

	// ==========================================================
	// Software registers
	logic [1:0]          bor_ctrl;
	logic                osc_check;
	logic [31:0]         wdt_load;
	logic [1:0]          wdt_ctrl;
	logic [31:0]         wdt_count;
	logic                wdt_flag;
	logic [REG_BITS-1:0] preg [NUM_REGS];
	logic [CAUSE_W-1:0]  cause;
	seq_state_type       state;
	logic                in_reset;
	assign in_reset = (state != ST_RUN);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	logic sw_req;
	logic wdt_zero;
	logic wdt_reset;
	logic osc_event;
	logic bor_reset;
	assign sw_req    = wr_i && hit(addr_i, OFF_CORE_RST) && wdata_i[SYSREQ_BIT]; // R16
	assign wdt_zero  = wdt_ctrl[WDT_EN_BIT] && (wdt_count == 32'h00000000);
	assign wdt_reset = wdt_zero && wdt_flag && wdt_ctrl[WDT_RST_EN_BIT]; // R19
	assign osc_event = osc_check && osc_level && !osc_prev; // R21
	assign bor_reset = bor_level && bor_ctrl[BOR_RST_EN_BIT]; // R14

	// Brown-out control only clears at power-on, else it would disable itself
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bor_ctrl  <= 2'h0; // R12
			osc_check <= 1'b0;
		end else if (wr_i) begin
			if (hit(addr_i, OFF_BOR_CTRL)) begin
				bor_ctrl <= wdata_i[1:0]; // R12
			end
			if (hit(addr_i, OFF_OSC_CTRL)) begin
				osc_check <= wdata_i[OSC_CHK_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_prev <= 1'b0;
		end else begin
			osc_prev <= osc_level;
		end
	end

	// Bit i of register r resets the unit at the same clock-gate position
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int r = 0; r < NUM_REGS; r++) begin
				preg[r] <= '0;
			end
		end else if (in_reset) begin
			for (int r = 0; r < NUM_REGS; r++) begin
				preg[r] <= '0;
			end
		end else if (wr_i) begin
			for (int r = 0; r < NUM_REGS; r++) begin
				if (addr_i == OFF_PRST0 + 8'(4 * r)) begin
					preg[r] <= wdata_i; // R4 R6
				end
			end
		end
	end

	// ==========================================================
	// Watchdog
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdt_load  <= WDT_LOAD_RST;
			wdt_ctrl  <= 2'h0;
			wdt_count <= WDT_LOAD_RST;
		end else if (in_reset) begin
			wdt_ctrl  <= 2'h0;
			wdt_count <= wdt_load;
		end else begin
			if (wr_i && hit(addr_i, OFF_WDT_LOAD)) begin
				wdt_load  <= wdata_i;
				wdt_count <= wdata_i;
			end else if (wdt_zero) begin
				wdt_count <= wdt_load; // R18
			end else if (wdt_ctrl[WDT_EN_BIT]) begin
				wdt_count <= wdt_count - 32'h00000001;
			end
			if (wr_i && hit(addr_i, OFF_WDT_CTRL)) begin
				wdt_ctrl <= wdata_i[1:0];
			end
		end
	end

	// First time-out sets the flag; a time-out beats a same-cycle clear
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdt_flag <= 1'b0;
		end else if (in_reset) begin
			wdt_flag <= 1'b0;
		end else if (wdt_zero) begin
			wdt_flag <= 1'b1; // R17
		end else if (wr_i && hit(addr_i, OFF_WDT_ICR)) begin
			wdt_flag <= 1'b0;
		end
	end

	// ==========================================================
	// Cause record: zero bits written clear, new events win
	logic [CAUSE_W-1:0] events;
	always_comb begin
		events            = '0;
		events[CAUSE_EXT] = ext_active;
		events[CAUSE_BOR] = bor_reset;
		events[CAUSE_SW]  = sw_req;
		events[CAUSE_WDT] = wdt_reset;
		events[CAUSE_OSC] = osc_event;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cause <= CAUSE_POR_VAL; // R8
		end else if (wr_i && hit(addr_i, OFF_CAUSE)) begin
			cause <= (cause & wdata_i[CAUSE_W-1:0]) | events; // R7 R23
		end else begin
			cause <= cause | events; // R7
		end
	end

	// ==========================================================
	// Release sequencer
	logic       level_src;
	logic       any_src;
	logic [7:0] hold_cnt;
	logic       osc_pending;
	assign level_src = ext_active || bor_reset; // R15
	assign any_src   = level_src || sw_req || wdt_reset || osc_event; // R3

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state    <= ST_ASSERT; // R9
			hold_cnt <= 8'h00;
		end else begin
			case (state)
				ST_ASSERT: begin
					if (!level_src) begin
						state    <= ST_WAIT;
						hold_cnt <= 8'(RELEASE_CYC);
					end
				end
				ST_WAIT: begin
					// A pulse request in the hold restarts it, so release never hides it
					if (level_src) begin
						state <= ST_ASSERT;
					end else if (any_src) begin
						hold_cnt <= 8'(RELEASE_CYC); // R3 R16
					end else if (hold_cnt == 8'h01) begin
						state <= ST_RUN; // R9 R16
					end else begin
						hold_cnt <= hold_cnt - 8'h01;
					end
				end
				ST_RUN: begin
					if (any_src) begin
						state <= ST_ASSERT; // R2 R3 R13
					end
				end
				default: begin
					state <= ST_ASSERT;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_pending <= 1'b0;
		end else if (osc_event) begin
			osc_pending <= 1'b1;
		end else if (state == ST_RUN) begin
			osc_pending <= 1'b0;
		end
	end

	// ==========================================================
	// Registered outputs
	logic next_run;
	assign next_run = (state == ST_WAIT) && !any_src && (hold_cnt == 8'h01);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_reset_n_o        <= 1'b0; // R1
			periph_reset_n_o      <= 1'b0; // R1
			tap_reset_n_o         <= 1'b0; // R1 R10
			tap_pin_cfg_reset_n_o <= 1'b0;
			unit_reset_n_o        <= '0;
			boot_fetch_o          <= 1'b0;
			nmi_request_o         <= 1'b0;
			brownout_irq_o        <= 1'b0;
			watchdog_irq_o        <= 1'b0;
		end else begin
			// From the next state, so release and boot fetch share one edge
			core_reset_n_o        <= next_run || (state == ST_RUN && !any_src); // R9
			periph_reset_n_o      <= next_run || (state == ST_RUN && !any_src); // R9
			tap_reset_n_o         <= 1'b1; // R2 R3
			tap_pin_cfg_reset_n_o <= !ext_active; // R2
			for (int r = 0; r < NUM_REGS; r++) begin
				unit_reset_n_o[r*REG_BITS +: REG_BITS] <= ~preg[r]; // R4 R5
			end
			boot_fetch_o          <= next_run; // R9 R16
			nmi_request_o         <= next_run && osc_pending; // R21
			brownout_irq_o        <= bor_level && bor_ctrl[BOR_IRQ_EN_BIT]
				&& !bor_ctrl[BOR_RST_EN_BIT]; // R13
			watchdog_irq_o        <= wdt_flag; // R17
		end
	end

	// ==========================================================
	// Register read port; data stands only in the following cycle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			rdata_o <= '0;
			case (addr_i)
				OFF_BOR_CTRL:  rdata_o <= {30'h0, bor_ctrl};
				OFF_CAUSE:     rdata_o <= {26'h0, cause};
				OFF_WDT_LOAD:  rdata_o <= wdt_load;
				OFF_WDT_CTRL:  rdata_o <= {30'h0, wdt_ctrl};
				OFF_WDT_VALUE: rdata_o <= wdt_count;
				OFF_WDT_ICR:   rdata_o <= {31'h0, wdt_flag};
				OFF_OSC_CTRL:  rdata_o <= {31'h0, osc_check};
				default: begin
					for (int r = 0; r < NUM_REGS; r++) begin
						if (addr_i == OFF_PRST0 + 8'(4 * r)) begin
							rdata_o <= preg[r];
						end
					end
				end
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_tap_never_reset: assert property (!tap_reset_n_o |-> !$past(rst_n_i)) // R3
		else $error("TAP reset after power-on");
	a_pin_holds_core: assert property (ext_active |=> !core_reset_n_o) // R2
		else $error("Core left running with pin asserted");
	a_bor_needs_enable: assert property (bor_level && !bor_ctrl[BOR_RST_EN_BIT]
		&& state == ST_RUN && !ext_active && !sw_req && !wdt_reset && !osc_event
		|=> state == ST_RUN) // R14
		else $error("Brown-out reset while disabled");
	a_bor_holds_reset: assert property (bor_reset |=> state == ST_ASSERT) // R15
		else $error("Brown-out reset not held");
	a_sw_request_reset: assert property (sw_req |=> !core_reset_n_o ##1 !core_reset_n_o) // R16
		else $error("System reset request ignored");
	a_wdt_second_reset: assert property (wdt_reset |=> state == ST_ASSERT) // R19
		else $error("Watchdog second time-out did not reset");
	a_wdt_first_irq: assert property (wdt_zero && !wdt_flag && !in_reset
		|=> wdt_flag && wdt_count == $past(wdt_load)) // R17 R18
		else $error("First time-out handling wrong");
	a_cause_sticky: assert property (!(wr_i && hit(addr_i, OFF_CAUSE))
		|=> (cause & $past(cause)) == $past(cause)) // R7
		else $error("Cause flag lost");
	a_release_fetch: assert property ($rose(core_reset_n_o) |-> boot_fetch_o) // R9
		else $error("Release without vector fetch");
	a_osc_nmi: assert property (osc_event |-> ##[1:40] nmi_request_o) // R21
		else $error("Oscillator failure gave no NMI");
	a_unit_reset: assert property (wr_i && addr_i == OFF_PRST0 && wdata_i[0] && !in_reset
		|=> ##1 !unit_reset_n_o[0] && core_reset_n_o == $past(core_reset_n_o)) // R4 R5
		else $error("Unit reset wrong");
endmodule
`default_nettype wire

// File: bench/reset_board_model.sv
// Board reset circuit and on-chip reset requesters
`timescale 1ns/1ps
`default_nettype none
module reset_board_model #(
	parameter int MIN_PULSE = 4
) (
	input  wire logic ref_clk_i,
	output logic      ext_reset_n_o,
	output logic      brownout_detect_o,
	output logic      osc_fail_o
);
	int low_cnt;
	// ==========================================================
	// Idle levels: pin has a pull-up
	initial begin
		ext_reset_n_o = 1'b1;
		brownout_detect_o = 1'b0;
		osc_fail_o = 1'b0;
		low_cnt = 0;
	end
	always @(posedge ref_clk_i) begin
		low_cnt <= (ext_reset_n_o === 1'b0) ? low_cnt + 1 : 0;
	end
	// ==========================================================
	// Requests
	task automatic pin_low();
		@(posedge ref_clk_i);
		ext_reset_n_o <= 1'b0;
	endtask
	// Release never comes early, however soon the bench asks
	task automatic pin_release();
		@(posedge ref_clk_i);
		while (low_cnt < MIN_PULSE) @(posedge ref_clk_i);
		ext_reset_n_o <= 1'b1;
	endtask
	task automatic set_brownout(input logic lvl);
		@(posedge ref_clk_i);
		brownout_detect_o <= lvl;
	endtask
	task automatic osc_pulse();
		@(posedge ref_clk_i);
		osc_fail_o <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		osc_fail_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: bench/tb_reset_source_controller.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`default_nettype none
module tb_reset_source_controller;
	import reset_source_pkg::*;
	logic              ref_clk_i, rst_n_i, wr_i, rd_i;
	logic              ext_n, bod, oscf;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i, rdata_o;
	logic              core_n, periph_n, tap_n, pincfg_n, boot, nmi, bor_irq, wdt_irq;
	logic [95:0]       unit_n, exp_units;
	int                n_fail, tests_run, cycles, seed, exp_cause, r, b, k;
	// ==========================================================
	// Clock, partner and design
	initial ref_clk_i = 1'b0;
	always #12.5 ref_clk_i = ~ref_clk_i;
	reset_board_model partner_u (.ref_clk_i(ref_clk_i), .ext_reset_n_o(ext_n),
		.brownout_detect_o(bod), .osc_fail_o(oscf));
	reset_source_controller dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.ext_reset_n_i(ext_n), .brownout_detect_i(bod), .osc_fail_i(oscf),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.core_reset_n_o(core_n), .periph_reset_n_o(periph_n), .tap_reset_n_o(tap_n),
		.tap_pin_cfg_reset_n_o(pincfg_n), .unit_reset_n_o(unit_n), .boot_fetch_o(boot),
		.nmi_request_o(nmi), .brownout_irq_o(bor_irq), .watchdog_irq_o(wdt_irq));
	// ==========================================================
	// Compare and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_units(input logic [95:0] exp);
		tests_run++;
		if (unit_n !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, unit_n, exp);
		end
	endtask
	// Order: core, peripherals, debug port, debug pin configuration
	task automatic chk_rst(input logic [3:0] exp);
		chk({28'h0, core_n, periph_n, tap_n, pincfg_n}, {28'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask
	task automatic wait_low(input int n);
		for (k = 0; k < n && core_n !== 1'b0; k++) begin
			@(posedge ref_clk_i);
			#1;
		end
		chk({31'h0, core_n}, 32'h0);
	endtask
	task automatic wait_release(input logic exp_nmi);
		for (k = 0; k < 300 && core_n !== 1'b1; k++) begin
			@(posedge ref_clk_i);
			#1;
		end
		chk({30'h0, boot, nmi}, {30'h0, 1'b1, exp_nmi});
		chk_rst(4'hF);
	endtask
	task automatic do_por();
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk_rst(4'h0);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		exp_cause = 32'h2;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Runaway guard, well above the longest path through the tests
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_fail++;
			summarize();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		{n_fail, tests_run, cycles} = '0;
		seed = 82672;
		{rst_n_i, wr_i, rd_i, addr_i, wdata_i} = '0;
		do_por();
		wait_release(1'b0);
		rd_chk(OFF_CAUSE, exp_cause);
		rd_chk(OFF_BOR_CTRL, 32'h0);
		rd_chk(8'hFC, 32'h0);
		$display("test power_on done");
		wr(OFF_CORE_RST, 32'h4);
		wait_low(4);
		chk_rst(4'h3);
		exp_cause |= 32'h8;
		wait_release(1'b0);
		rd_chk(OFF_CAUSE, exp_cause);
		$display("test software_request done");
		partner_u.pin_low();
		wait_low(10);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk_rst(4'h2);
		partner_u.pin_release();
		exp_cause |= 32'h1;
		wait_release(1'b0);
		rd_chk(OFF_CAUSE, exp_cause);
		$display("test reset_pin done");
		wr(OFF_BOR_CTRL, 32'h1);
		partner_u.set_brownout(1'b1);
		repeat (8) @(posedge ref_clk_i);
		#1;
		chk({30'h0, bor_irq, core_n}, 32'h3);
		wr(OFF_BOR_CTRL, 32'h3);
		wait_low(10);
		repeat (20) @(posedge ref_clk_i);
		#1;
		chk_rst(4'h3);
		partner_u.set_brownout(1'b0);
		exp_cause |= 32'h4;
		wait_release(1'b0);
		rd_chk(OFF_CAUSE, exp_cause);
		$display("test brownout done");
		for (r = 0; r < NUM_PREGS; r++) begin
			b = $unsigned($random(seed)) % PREG_BITS;
			exp_units = '1;
			exp_units[32*r+b] = 1'b0;
			wr(OFF_PRST0 + 8'(4*r), 32'h1 << b);
			@(posedge ref_clk_i);
			#1;
			chk_units(exp_units);
			chk_rst(4'hF);
			wr(OFF_PRST0 + 8'(4*r), 32'h0);
			@(posedge ref_clk_i);
			#1;
			chk_units('1);
		end
		$display("test unit_reset done");
		wr(OFF_WDT_LOAD, 32'h20);
		wr(OFF_WDT_CTRL, 32'h3);
		for (k = 0; k < 200 && wdt_irq !== 1'b1; k++) @(posedge ref_clk_i);
		#1;
		chk({30'h0, wdt_irq, core_n}, 32'h3);
		wait_low(40);
		exp_cause |= 32'h10;
		wait_release(1'b0);
		rd_chk(OFF_CAUSE, exp_cause);
		$display("test watchdog done");
		wr(OFF_WDT_CTRL, 32'h3);
		for (k = 0; k < 200 && wdt_irq !== 1'b1; k++) @(posedge ref_clk_i);
		wr(OFF_WDT_ICR, 32'h1);
		repeat (40) @(posedge ref_clk_i);
		#1;
		chk({30'h0, wdt_irq, core_n}, 32'h3);
		wr(OFF_WDT_CTRL, 32'h0);
		rd_chk(OFF_WDT_LOAD, 32'h20);
		$display("test watchdog_clear done");
		wr(OFF_OSC_CTRL, 32'h1);
		partner_u.osc_pulse();
		wait_low(10);
		chk_rst(4'h3);
		exp_cause |= 32'h20;
		wait_release(1'b1);
		rd_chk(OFF_CAUSE, exp_cause);
		$display("test osc_fail done");
		do_por();
		wait_release(1'b0);
		rd_chk(OFF_CAUSE, exp_cause);
		wr(OFF_CAUSE, 32'h0);
		exp_cause = 0;
		rd_chk(OFF_CAUSE, exp_cause);
		$display("test cause_clear done");
		summarize();
	end
endmodule
`default_nettype wire
